// *** design/envelope_timer.sv ***
// Envelope timer with 16-bit up counter and 9-bit carrier counter
`timescale 1ns/10ps

// Operation
// (R01) 16-bit up count on div4/8/16 or carrier
// (R02) Overflow request at FFFFH when enabled
// (R03) After overflow counter wraps to zero
// (R04) Writing clear bit zeroes the counter
// (R05) Match with reference: request, clear, resume
// (R06) Edge field picks rising, falling or both
// (R07) Timer vectors F4H/F6H, carrier ECH
// (R08) Overflow outranks match or capture
// (R09) Pending bit set by hardware, software clears
// (R10) Reset zeroes timer control register
// (R11) Count read-only bytes, reference read/write bytes
// (R12) Carrier 9-bit down counter auto-reloads
// (R13) Carrier raises periodic interrupt request
// (R14) Carrier flop can clock the timer
// (R15) Phase lengths are reference plus two
// (R16) Level bit swaps the phase references
// (R17) Carrier control: clock, enable, pending, time
// (R18) Repeat and one-shot modes, start/stop gate
// (R19) Software loads nonzero low reference first
// (R20) Capture copies count into reference registers
// (R21) Settings apply next tick, count preserved
module envelope_timer (
	// Clock and reset
	input  wire logic                          mclk_in,
	input  wire logic                          sys_rst_in,
	// Register bus
	input  wire envelope_timer_pkg::bus_req_t  bus_in,
	output logic [7:0]                         rdata_out,
	// Pins
	input  wire logic                          capture_input_pin_in,
	output logic                               carrier_output_pin_out,
	// Interrupt requests
	input  wire logic                          timer_irq_ack_in,
	output envelope_timer_pkg::irq_t           timer_irq_out,
	output envelope_timer_pkg::irq_t           carrier_irq_out
);

	// Whole state of the block
	typedef struct packed {
		logic [3:0]               presc;      // Free running prescaler
		logic [15:0]              tcnt;       // Timer count
		logic [15:0]              tref;       // Timer reference / capture
		logic [7:0]               tctl;       // Timer control
		logic                     ovf_pend;   // Overflow pending
		logic                     cap_prev;   // Last capture pin level
		logic [7:0]               cref_h;     // Carrier high reference
		logic [7:0]               cref_l;     // Carrier low reference
		logic [7:0]               cctl;       // Carrier control
		logic [8:0]               ccnt;       // Carrier down counter
		logic                     cout;       // Carrier output flop
		logic                     cout_prev;  // Last carrier flop level
		logic [7:0]               rdata;      // Read data
		envelope_timer_pkg::irq_t tirq;       // Timer interrupt request
		envelope_timer_pkg::irq_t cirq;       // Carrier interrupt request
	} state_t;

	state_t cur;       // Registered state
	state_t next_cur;  // Next state

	// Combinational working values
	logic                            t_tick;   // Timer clock tick
	logic                            c_tick;   // Carrier clock tick
	logic                            cap_hit;  // Selected capture edge seen
	logic                            c_term;   // Carrier phase ends
	logic [7:0]                      c_ref;    // Reference for next phase
	logic                            c_lvl;    // Carrier level bit
	envelope_timer_pkg::timer_mode_t t_mode;   // Timer mode field
	envelope_timer_pkg::timer_clk_t  t_csel;   // Timer clock field

	// Output drive straight from state flops
	assign rdata_out              = cur.rdata;
	assign carrier_output_pin_out = cur.cout;
	assign timer_irq_out          = cur.tirq;
	assign carrier_irq_out        = cur.cirq;

	// Next state logic
	always_comb
	begin
		next_cur = cur;
		t_mode   = envelope_timer_pkg::timer_mode_t'(cur.tctl[
			envelope_timer_pkg::TCTL_EDGE_HI_BIT:envelope_timer_pkg::TCTL_EDGE_LO_BIT]);
		t_csel   = envelope_timer_pkg::timer_clk_t'(cur.tctl[
			envelope_timer_pkg::TCTL_CSEL_HI_BIT:envelope_timer_pkg::TCTL_CSEL_LO_BIT]);
		c_lvl    = cur.cctl[envelope_timer_pkg::CCTL_LEVEL_BIT];

		// Prescaler always runs
		next_cur.presc     = cur.presc + 4'h1;
		next_cur.cap_prev  = capture_input_pin_in;
		next_cur.cout_prev = cur.cout;

		// Timer tick from the selected source, read afresh each cycle
		unique case (t_csel)                                                 // R21
			envelope_timer_pkg::TCLK_DIV4:    t_tick = (cur.presc[1:0] == 2'h3); // R01
			envelope_timer_pkg::TCLK_DIV8:    t_tick = (cur.presc[2:0] == 3'h7); // R01
			envelope_timer_pkg::TCLK_DIV16:   t_tick = (cur.presc == 4'hF);      // R01
			envelope_timer_pkg::TCLK_CARRIER: t_tick = cur.cout & ~cur.cout_prev; // R14
		endcase

		// Carrier tick: oscillator or divided by 2, 4, 8
		unique case (cur.cctl[envelope_timer_pkg::CCTL_CSEL_HI:envelope_timer_pkg::CCTL_CSEL_LO])
			2'h0:    c_tick = 1'b1;                                            // R17
			2'h1:    c_tick = cur.presc[0];
			2'h2:    c_tick = (cur.presc[1:0] == 2'h3);
			default: c_tick = (cur.presc[2:0] == 3'h7);
		endcase

		// Capture edge decode
		unique case (t_mode)                                                 // R06
			envelope_timer_pkg::TMODE_RISING:  cap_hit = capture_input_pin_in & ~cur.cap_prev;
			envelope_timer_pkg::TMODE_FALLING: cap_hit = ~capture_input_pin_in & cur.cap_prev;
			envelope_timer_pkg::TMODE_BOTH:    cap_hit = capture_input_pin_in ^ cur.cap_prev;
			default:                           cap_hit = 1'b0;
		endcase

		// Read path: data stand in the cycle after the strobe only
		next_cur.rdata = 8'h00;
		if (bus_in.rd)
		begin
			unique case (bus_in.addr)
				envelope_timer_pkg::ADDR_CARRIER_CONTROL:  next_cur.rdata = cur.cctl;
				envelope_timer_pkg::ADDR_CARRIER_REF_HIGH: next_cur.rdata = cur.cref_h;
				envelope_timer_pkg::ADDR_CARRIER_REF_LOW:  next_cur.rdata = cur.cref_l;
				envelope_timer_pkg::ADDR_TIMER_COUNT_HIGH: next_cur.rdata = cur.tcnt[15:8]; // R11
				envelope_timer_pkg::ADDR_TIMER_COUNT_LOW:  next_cur.rdata = cur.tcnt[7:0];  // R11
				envelope_timer_pkg::ADDR_TIMER_REF_HIGH:   next_cur.rdata = cur.tref[15:8]; // R11
				envelope_timer_pkg::ADDR_TIMER_REF_LOW:    next_cur.rdata = cur.tref[7:0];  // R11
				envelope_timer_pkg::ADDR_TIMER_CONTROL:    next_cur.rdata = cur.tctl;
				default:                                   next_cur.rdata = 8'h00;
			endcase
		end

		// Register writes; count bytes ignore writes
		if (bus_in.wr)
		begin
			unique case (bus_in.addr)
				envelope_timer_pkg::ADDR_CARRIER_CONTROL:
				begin
					next_cur.cctl = bus_in.wdata;
					// Pending bit: writing zero clears, writing one keeps
					next_cur.cctl[envelope_timer_pkg::CCTL_PEND_BIT] =            // R17
						cur.cctl[envelope_timer_pkg::CCTL_PEND_BIT] &
						bus_in.wdata[envelope_timer_pkg::CCTL_PEND_BIT];
				end
				envelope_timer_pkg::ADDR_CARRIER_REF_HIGH: next_cur.cref_h = bus_in.wdata;
				envelope_timer_pkg::ADDR_CARRIER_REF_LOW:  next_cur.cref_l = bus_in.wdata;
				envelope_timer_pkg::ADDR_TIMER_REF_HIGH:   next_cur.tref[15:8] = bus_in.wdata; // R11
				envelope_timer_pkg::ADDR_TIMER_REF_LOW:    next_cur.tref[7:0] = bus_in.wdata;  // R11
				envelope_timer_pkg::ADDR_TIMER_CONTROL:
				begin
					next_cur.tctl = bus_in.wdata;
					// Clear bit acts at once and is never stored
					next_cur.tctl[envelope_timer_pkg::TCTL_CLEAR_BIT] = 1'b0;
					// Pending bit is cleared only by writing zero
					next_cur.tctl[envelope_timer_pkg::TCTL_PEND_BIT] =               // R09
						cur.tctl[envelope_timer_pkg::TCTL_PEND_BIT] &
						bus_in.wdata[envelope_timer_pkg::TCTL_PEND_BIT];
				end
				default:
				begin
				end
			endcase
		end

		// Timer counting on its tick
		if (t_tick)
		begin
			if (cur.tcnt == envelope_timer_pkg::TIMER_COUNT_MAX)
			begin
				// Wrap and request overflow when enabled
				next_cur.tcnt = envelope_timer_pkg::TIMER_COUNT_ZERO;              // R03
				if (cur.tctl[envelope_timer_pkg::TCTL_OVIE_BIT])
					next_cur.ovf_pend = 1'b1;                                        // R02
			end
			else if (t_mode == envelope_timer_pkg::TMODE_INTERVAL && cur.tcnt == cur.tref)
			begin
				// Match: clear count and flag it
				next_cur.tcnt = envelope_timer_pkg::TIMER_COUNT_ZERO;              // R05
				next_cur.tctl[envelope_timer_pkg::TCTL_PEND_BIT] = 1'b1;           // R05
			end
			else
			begin
				next_cur.tcnt = cur.tcnt + 16'h0001;                               // R01
			end
		end

		// Capture copies the count and flags it, over a software write
		if (cap_hit)
		begin
			next_cur.tref = cur.tcnt;                                            // R20
			next_cur.tctl[envelope_timer_pkg::TCTL_PEND_BIT] = 1'b1;             // R09
		end

		// Software clear wins over counting
		if (bus_in.wr && bus_in.addr == envelope_timer_pkg::ADDR_TIMER_CONTROL &&
			bus_in.wdata[envelope_timer_pkg::TCTL_CLEAR_BIT])
			next_cur.tcnt = envelope_timer_pkg::TIMER_COUNT_ZERO;                // R04

		// Overflow pending is dropped once its vector is acknowledged
		if (timer_irq_ack_in && cur.tirq.vector == envelope_timer_pkg::VEC_TIMER_OVERFLOW &&
			!(t_tick && cur.tcnt == envelope_timer_pkg::TIMER_COUNT_MAX))
			next_cur.ovf_pend = 1'b0;

		// Reference for the phase that follows the current one
		c_ref = (~cur.cout ^ c_lvl) ? cur.cref_h : cur.cref_l;                 // R16
		c_term = c_tick && cur.ccnt == 9'h000;

		// Carrier counter
		if (!cur.cctl[envelope_timer_pkg::CCTL_RUN_BIT])
		begin
			// Stopped: output low, low phase preloaded
			next_cur.cout = 1'b0;                                                // R18
			next_cur.ccnt = {1'b0, c_lvl ? cur.cref_h : cur.cref_l} + 9'h001;    // R15
		end
		else if (c_term)
		begin
			// Phase end: toggle and reload, ref plus two ticks per phase
			next_cur.cout = ~cur.cout;                                           // R12
			next_cur.ccnt = {1'b0, c_ref} + 9'h001;                              // R15
			// Interrupt time: end of high phase or end of low phase
			if (cur.cout ^ cur.cctl[envelope_timer_pkg::CCTL_ITIME_BIT])
				next_cur.cctl[envelope_timer_pkg::CCTL_PEND_BIT] = 1'b1;         // R13
			// One-shot stops after its high phase
			if (cur.cout && !cur.cctl[envelope_timer_pkg::CCTL_REPEAT_BIT])
			begin
				next_cur.cout = 1'b0;                                            // R18
				next_cur.cctl[envelope_timer_pkg::CCTL_RUN_BIT] = 1'b0;          // R18
			end
		end
		else if (c_tick)
		begin
			next_cur.ccnt = cur.ccnt - 9'h001;                                   // R12
		end

		// Timer interrupt level and vector, overflow first
		next_cur.tirq.level = next_cur.ovf_pend |
			(next_cur.tctl[envelope_timer_pkg::TCTL_PEND_BIT] &
			next_cur.tctl[envelope_timer_pkg::TCTL_MCIE_BIT]);                   // R07
		next_cur.tirq.vector = next_cur.ovf_pend ? envelope_timer_pkg::VEC_TIMER_OVERFLOW :
			envelope_timer_pkg::VEC_TIMER_MATCH;                                 // R08

		// Carrier interrupt level and vector
		next_cur.cirq.level = next_cur.cctl[envelope_timer_pkg::CCTL_PEND_BIT] &
			next_cur.cctl[envelope_timer_pkg::CCTL_IE_BIT];                      // R13
		next_cur.cirq.vector = envelope_timer_pkg::VEC_CARRIER;                  // R07
	end

	// State register with synchronous reset
	always_ff @(posedge mclk_in)
	begin
		if (sys_rst_in)
		begin
			cur             <= '0;
			cur.tctl        <= envelope_timer_pkg::TIMER_CONTROL_RESET;          // R10
			cur.tref        <= envelope_timer_pkg::TIMER_REF_RESET;
			cur.cctl        <= envelope_timer_pkg::CARRIER_CONTROL_RESET;
			cur.cref_h      <= envelope_timer_pkg::CARRIER_REF_RESET;
			cur.cref_l      <= envelope_timer_pkg::CARRIER_REF_RESET;
			cur.tirq.vector <= envelope_timer_pkg::VEC_TIMER_MATCH;
			cur.cirq.vector <= envelope_timer_pkg::VEC_CARRIER;
		end
		else
		begin
			cur <= next_cur;
		end
	end

endmodule

// *** design/envelope_timer_pkg.sv ***
// Constants, register map and types of the envelope timer block
package envelope_timer_pkg;

	// Register byte addresses
	localparam logic [7:0] ADDR_CARRIER_CONTROL  = 8'hF3;
	localparam logic [7:0] ADDR_CARRIER_REF_HIGH = 8'hF4;
	localparam logic [7:0] ADDR_CARRIER_REF_LOW  = 8'hF5;
	localparam logic [7:0] ADDR_TIMER_COUNT_HIGH = 8'hF6;
	localparam logic [7:0] ADDR_TIMER_COUNT_LOW  = 8'hF7;
	localparam logic [7:0] ADDR_TIMER_REF_HIGH   = 8'hF8;
	localparam logic [7:0] ADDR_TIMER_REF_LOW    = 8'hF9;
	localparam logic [7:0] ADDR_TIMER_CONTROL    = 8'hFA;

	// Timer control field positions
	localparam int TCTL_PEND_BIT    = 0;
	localparam int TCTL_MCIE_BIT    = 1;
	localparam int TCTL_OVIE_BIT    = 2;
	localparam int TCTL_CLEAR_BIT   = 3;
	localparam int TCTL_EDGE_LO_BIT = 4;
	localparam int TCTL_EDGE_HI_BIT = 5;
	localparam int TCTL_CSEL_LO_BIT = 6;
	localparam int TCTL_CSEL_HI_BIT = 7;

	// Carrier control field positions
	localparam int CCTL_LEVEL_BIT  = 0;
	localparam int CCTL_REPEAT_BIT = 1;
	localparam int CCTL_RUN_BIT    = 2;
	localparam int CCTL_PEND_BIT   = 3;
	localparam int CCTL_IE_BIT     = 4;
	localparam int CCTL_ITIME_BIT  = 5;
	localparam int CCTL_CSEL_LO    = 6;
	localparam int CCTL_CSEL_HI    = 7;

	// Reset values
	localparam logic [7:0]  TIMER_CONTROL_RESET   = 8'h00;
	localparam logic [7:0]  CARRIER_CONTROL_RESET = 8'h00;
	localparam logic [15:0] TIMER_REF_RESET       = 16'hFFFF;
	localparam logic [7:0]  CARRIER_REF_RESET     = 8'h01;

	// Counter limits
	localparam logic [15:0] TIMER_COUNT_MAX = 16'hFFFF;
	localparam logic [15:0] TIMER_COUNT_ZERO = 16'h0000;

	// Interrupt vectors
	localparam logic [7:0] VEC_TIMER_OVERFLOW = 8'hF4;
	localparam logic [7:0] VEC_TIMER_MATCH    = 8'hF6;
	localparam logic [7:0] VEC_CARRIER        = 8'hEC;

	// Timer mode / edge select codes
	typedef enum logic [1:0] {
		TMODE_INTERVAL = 2'h0,
		TMODE_RISING   = 2'h1,
		TMODE_FALLING  = 2'h2,
		TMODE_BOTH     = 2'h3
	} timer_mode_t;

	// Timer clock select codes
	typedef enum logic [1:0] {
		TCLK_DIV4    = 2'h0,
		TCLK_DIV8    = 2'h1,
		TCLK_DIV16   = 2'h2,
		TCLK_CARRIER = 2'h3
	} timer_clk_t;

	// Register bus request
	typedef struct packed {
		logic [7:0] addr;
		logic [7:0] wdata;
		logic       wr;
		logic       rd;
	} bus_req_t;

	// Interrupt request with its vector
	typedef struct packed {
		logic       level;
		logic [7:0] vector;
	} irq_t;

endpackage

// *** dv/envelope_timer_assertions.sv ***
// Port-level checker for the envelope timer
`timescale 1ns/10ps
module envelope_timer_checker (
	// Clock and reset
	input wire logic                         mclk_in,
	input wire logic                         sys_rst_in,
	// Register bus and pins
	input wire envelope_timer_pkg::bus_req_t bus_in,
	input wire logic [7:0]                   rdata_out,
	input wire logic                         capture_input_pin_in,
	input wire logic                         carrier_output_pin_out,
	// Interrupts
	input wire logic                         timer_irq_ack_in,
	input wire envelope_timer_pkg::irq_t     timer_irq_out,
	input wire envelope_timer_pkg::irq_t     carrier_irq_out
);
	// Single clock domain
	default clocking cb @(posedge mclk_in);
	endclocking
	default disable iff (sys_rst_in);
	// Read strobe at one address
	sequence rd_at(logic [7:0] a);
		bus_in.rd && bus_in.addr == a;
	endsequence
	// Acknowledge while a match request is shown
	sequence match_acked;
		timer_irq_out.level && timer_irq_out.vector == 8'hF6 && timer_irq_ack_in && !bus_in.wr;
	endsequence
	// Read data is zero outside answers
	chk_rdata_idle: assert property (!bus_in.rd |=> rdata_out == 8'h00)
		else $error("read data not zero when idle");
	// Unmapped space below F3H reads zero
	chk_unmapped_zero: assert property (bus_in.rd && bus_in.addr < 8'hF3 |=> !rdata_out)
		else $error("unmapped read not zero");
	// Clear bit never reads back as one
	chk_clear_reads0: assert property (rd_at(8'hFA) |=> !rdata_out[3])
		else $error("clear bit read as one");
	// Outputs quiet right after reset
	chk_reset_quiet: assert property (
		$fell(sys_rst_in) |-> !(timer_irq_out.level | carrier_irq_out.level | carrier_output_pin_out))
		else $error("outputs active after reset");
	// Carrier vector fixed
	chk_carrier_vector: assert property (carrier_irq_out.vector == 8'hEC)
		else $error("carrier vector wrong");
	// Idle timer request shows the match vector
	chk_timer_vector: assert property (!timer_irq_out.level |-> timer_irq_out.vector == 8'hF6)
		else $error("timer vector wrong");
	// Acknowledge does not drop a match request
	chk_match_held: assert property (match_acked |=> timer_irq_out.level)
		else $error("match request cleared by ack");
	// Stopping forces the carrier low
	chk_carrier_stop: assert property (
		bus_in.wr && bus_in.addr == 8'hF3 && !bus_in.wdata[2] |-> ##2 !carrier_output_pin_out)
		else $error("carrier not low after stop");
	// A low phase lasts at least three clock cycles
	chk_low_phase: assert property ($fell(carrier_output_pin_out) |-> !carrier_output_pin_out [*3])
		else $error("carrier low phase too short");
endmodule

bind envelope_timer envelope_timer_checker u_chk (
	.mclk_in                (mclk_in),
	.sys_rst_in             (sys_rst_in),
	.bus_in                 (bus_in),
	.rdata_out              (rdata_out),
	.capture_input_pin_in   (capture_input_pin_in),
	.carrier_output_pin_out (carrier_output_pin_out),
	.timer_irq_ack_in       (timer_irq_ack_in),
	.timer_irq_out          (timer_irq_out),
	.carrier_irq_out        (carrier_irq_out)
);

// *** dv/tb_top.sv ***
// Self-checking bench for the envelope timer
`timescale 1ns/10ps
module tb_top;
	logic                         mclk_in;     // Clock
	logic                         sys_rst_in;  // Reset
	envelope_timer_pkg::bus_req_t bus_in;      // Bus request
	logic [7:0]                   rdata_out;   // Read data
	logic                         cap_pin;     // Capture pin
	logic                         carrier_out; // Carrier flop
	logic                         ack;         // Interrupt ack
	envelope_timer_pkg::irq_t     timer_irq;   // Timer request
	envelope_timer_pkg::irq_t     carrier_irq; // Carrier request
	int                           fails;       // Mismatches
	int                           num_checks;  // Comparisons
	int                           cycles;      // Timeout count
	int                           model[int];  // Read/write register model
	logic [31:0]                  seed;        // Random state
	logic [7:0]                   rd;          // Last read
	logic [7:0]                   addrs[7];    // Reset table addresses
	logic [7:0]                   exps[7];     // Reset table values
	int                           n, a, b, lo, hi;
	logic                         t;
	envelope_timer u_dut (
		.mclk_in                (mclk_in),
		.sys_rst_in             (sys_rst_in),
		.bus_in                 (bus_in),
		.rdata_out              (rdata_out),
		.capture_input_pin_in   (cap_pin),
		.carrier_output_pin_out (carrier_out),
		.timer_irq_ack_in       (ack),
		.timer_irq_out          (timer_irq),
		.carrier_irq_out        (carrier_irq)
	);
	// 50 ns clock
	always #25 mclk_in = ~mclk_in;
	// Hang guard
	always @(posedge mclk_in)
	begin
		cycles <= cycles + 1;
		if (cycles == 20000)
		begin
			fails++;
			results();
		end
	end
	// Xorshift source
	function automatic logic [31:0] xs();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction
	// Compare and count
	task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
		num_checks++;
		if (seen !== exp)
		begin
			fails++;
			$display("BAD %s expected %h seen %h", what, exp, seen);
		end
	endtask
	// One write cycle, model follows
	task automatic wr(input logic [7:0] ad, input logic [7:0] d);
		bus_in <= '{ad, d, 1'b1, 1'b0};
		if (model.exists(ad))
			model[ad] = d;
		@(posedge mclk_in);
		bus_in <= '0;
		@(posedge mclk_in);
	endtask
	// One read cycle, data taken in the next cycle
	task automatic rdr(input logic [7:0] ad);
		bus_in <= '{ad, 8'h00, 1'b0, 1'b1};
		@(posedge mclk_in);
		bus_in <= '0;
		#1 rd = rdata_out;
		@(posedge mclk_in);
	endtask
	// Cycles until the carrier level changes
	task automatic phase(output int len);
		logic v;
		v = carrier_out;
		for (len = 0; len < 100 && carrier_out === v; len++)
			@(posedge mclk_in) #1;
	endtask
	// Counts and verdict
	task automatic results();
		$display("Checks %0d mismatches %0d", num_checks, fails);
		if (fails == 0 && num_checks > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask
	// Main sequence
	initial
	begin
		mclk_in = 1'b0;
		sys_rst_in = 1'b1;
		bus_in = '0;
		cap_pin = 1'b0;
		ack = 1'b0;
		fails = 0;
		num_checks = 0;
		cycles = 0;
		seed = 32'hBF3C;
		model[8'hF8] = 8'hFF;
		model[8'hF9] = 8'hFF;
		addrs = '{8'hF3, 8'hF4, 8'hF5, 8'hF8, 8'hF9, 8'hFA, 8'hF0};
		exps = '{8'h00, 8'h01, 8'h01, 8'hFF, 8'hFF, 8'h00, 8'h00};
		repeat (2) @(posedge mclk_in);
		sys_rst_in <= 1'b0;
		@(posedge mclk_in);
		for (int i = 0; i < 7; i++)
		begin
			rdr(addrs[i]);
			check("reset value", rd, exps[i]);
		end
		repeat (40) @(posedge mclk_in);
		wr(8'hFA, 8'h08);
		rdr(8'hF7);
		check("cleared count", {7'h00, rd > 8'h01}, 8'h00);
		rdr(8'hFA);
		check("clear bit", rd, 8'h00);
		wr(8'hF0, 8'h55);
		wr(8'hF6, 8'hAA);
		rdr(8'hF0);
		check("unmapped", rd, 8'h00);
		rdr(8'hF6);
		check("count high", rd, 8'h00);
		$display("Registers done");
		wr(8'hF8, 8'h00);
		wr(8'hF9, 8'h05);
		rdr(8'hF8);
		check("ref high", rd, 8'(model[8'hF8]));
		rdr(8'hF9);
		check("ref low", rd, 8'(model[8'hF9]));
		wr(8'hFA, 8'h02);
		for (n = 0; n < 300 && timer_irq.level !== 1'b1; n++)
			@(posedge mclk_in);
		check("match level", timer_irq.level, 1'b1);
		check("match vector", timer_irq.vector, 8'hF6);
		rdr(8'hFA);
		check("pending set", rd, 8'h03);
		ack <= 1'b1;
		@(posedge mclk_in);
		ack <= 1'b0;
		@(posedge mclk_in);
		#1 check("held by ack", timer_irq.level, 1'b1);
		// Park the reference far above the count so no new match races the clear
		wr(8'hF8, 8'hFF);
		wr(8'hFA, 8'h02);
		#1 check("pending cleared", timer_irq.level, 1'b0);
		wr(8'hF8, 8'h00);
		repeat (200) @(posedge mclk_in);
		rdr(8'hF7);
		check("count bound", {7'h00, rd > 8'h05}, 8'h00);
		$display("Match done");
		for (int m = 1; m < 4; m++)
		begin
			wr(8'hFA, {2'b00, m[1:0], 4'h0});
			cap_pin <= 1'b1;
			repeat (3) @(posedge mclk_in);
			rdr(8'hFA);
			check("rise capture", rd[0], m[0]);
			wr(8'hFA, {2'b00, m[1:0], 4'h0});
			cap_pin <= 1'b0;
			repeat (3) @(posedge mclk_in);
			rdr(8'hFA);
			check("fall capture", rd[0], m[1]);
		end
		$display("Capture done");
		for (int lev = 0; lev < 2; lev++)
		begin
			lo = int'(xs() % 6) + 1;
			hi = int'(xs() % 6) + 1;
			wr(8'hF5, 8'(lo));
			wr(8'hF4, 8'(hi));
			wr(8'hF3, 8'h06 | 8'(lev));
			#1 phase(n);
			t = carrier_out;
			phase(a);
			phase(b);
			check("high phase", 8'(t ? a : b), 8'((lev ? lo : hi) + 2));
			check("low phase", 8'(t ? b : a), 8'((lev ? hi : lo) + 2));
			wr(8'hF3, 8'h00);
		end
		wr(8'hF3, 8'h16);
		for (n = 0; n < 300 && carrier_irq.level !== 1'b1; n++)
			@(posedge mclk_in);
		check("carrier level", carrier_irq.level, 1'b1);
		rdr(8'hF3);
		check("carrier pending", rd, 8'h1E);
		wr(8'hF3, 8'h00);
		#1 check("carrier cleared", carrier_irq.level, 1'b0);
		wr(8'hF5, 8'h01);
		wr(8'hF4, 8'h03);
		wr(8'hF3, 8'h04);
		n = 0;
		repeat (40)
		begin
			@(posedge mclk_in);
			#1 n += carrier_out;
		end
		check("pulse width", 8'(n), 8'h05);
		rdr(8'hF3);
		check("one-shot stop", rd & 8'h04, 8'h00);
		$display("Carrier done");
		results();
	end
endmodule
